// file: hw/gpc_ports.sv
// Ports C, D and E with peripheral override and parallel slave port, APB registers
module gpc_ports
  import gpc_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [GPC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] port_c_in, // Port C pin levels
  output logic [7:0] port_c_out, // Port C pin drive value
  output logic [7:0] port_c_oe, // Port C driver enable
  input wire logic [7:0] periph_sel, // Per pin: peripheral owns the pin
  input wire logic [7:0] periph_out, // Peripheral output values
  input wire logic [7:0] periph_oe, // Peripheral wants to drive the pin
  input wire logic [7:0] port_d_in, // Port D pin levels
  output logic [7:0] port_d_out, // Port D pin drive value
  output logic [7:0] port_d_oe, // Port D driver enable
  input wire logic [2:0] port_e_in, // Port E pin levels
  output logic [2:0] port_e_out, // Port E pin drive value
  output logic [2:0] port_e_oe // Port E driver enable
);

  gpc_state_t st_r;
  gpc_state_t st_nxt;

  localparam gpc_state_t ST_RESET = '{
    c_dir: RST_PORT_DIRECTION,
    d_dir: RST_PORT_DIRECTION,
    e_dir: RST_PORT_E_DIRECTION,
    e_analog: RST_ANALOG_SELECT,
    c_latch: RST_LATCH,
    d_latch: RST_LATCH,
    default: '0
  };

  logic [GPC_IDX_W-1:0] idx;
  logic setup;
  logic access;
  logic wr_now;
  logic rd_now;
  logic wr_act_now;
  logic rd_act_now;
  logic wr_end;
  logic rd_start;
  logic [7:0] e_ctrl;
  logic [7:0] c_oe_calc;
  logic [7:0] c_out_calc;

  assign idx = paddr[GPC_ADDR_W-1:2];
  assign setup = psel && !penable;
  assign access = psel && penable && st_r.pready;
  assign wr_now = access && pwrite && pstrb[0];
  assign rd_now = access && !pwrite;

  // ***********************************************
  // Slave-port strobes, taken only from synchronised pins
  // ***********************************************
  assign wr_act_now = st_r.mode && !st_r.e_sync2[PIN_CHIP_SELECT] &&
                      !st_r.e_sync2[PIN_WRITE_STROBE];
  assign rd_act_now = st_r.mode && !st_r.e_sync2[PIN_CHIP_SELECT] &&
                      !st_r.e_sync2[PIN_READ_STROBE];
  assign wr_end = st_r.wr_act && !wr_act_now;
  assign rd_start = rd_act_now && !st_r.rd_act;

  assign e_ctrl = {st_r.input_word_waiting, st_r.output_word_pending, st_r.input_overrun, st_r.mode, 1'b0, st_r.e_dir};

  // Peripheral enable only counts on pins the peripheral owns
  assign c_oe_calc = (periph_sel & periph_oe) | (~periph_sel & ~st_r.c_dir);
  assign c_out_calc = (periph_sel & periph_out) | (~periph_sel & st_r.c_latch);

  always_comb begin
    st_nxt = st_r;

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    st_nxt.c_sync1 = port_c_in;
    st_nxt.c_sync2 = st_r.c_sync1;
    st_nxt.d_sync1 = port_d_in;
    st_nxt.d_sync2 = st_r.d_sync1;
    st_nxt.e_sync1 = port_e_in;
    st_nxt.e_sync2 = st_r.e_sync1;

    // ***********************************************
    // Slave-port transfers from the external processor
    // ***********************************************
    st_nxt.wr_act = wr_act_now;
    st_nxt.rd_act = rd_act_now;
    if (wr_act_now) begin
      st_nxt.d_in_latch = st_r.d_sync2;
    end
    if (wr_end) begin
      st_nxt.input_word_waiting = 1'b1;
      if (st_r.input_word_waiting) begin
        st_nxt.input_overrun = 1'b1;
      end
    end
    if (rd_start) begin
      st_nxt.output_word_pending = 1'b0;
    end

    // ***********************************************
    // APB slave: one wait-free access phase
    // ***********************************************
    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
      if (idx == IDX_PORT_C_PINS) begin
        st_nxt.prdata[7:0] = st_r.c_sync2;
      end else if (idx == IDX_PORT_D_PINS) begin
        st_nxt.prdata[7:0] = st_r.mode ? st_r.d_in_latch : st_r.d_sync2;
      end else if (idx == IDX_PORT_E_PINS) begin
        st_nxt.prdata[2:0] = st_r.e_sync2 & ~st_r.e_analog;
      end else if (idx == IDX_PORT_C_DIRECTION) begin
        st_nxt.prdata[7:0] = st_r.c_dir;
      end else if (idx == IDX_PORT_D_DIRECTION) begin
        st_nxt.prdata[7:0] = st_r.d_dir;
      end else if (idx == IDX_PORT_E_DIRECTION_SLAVE_CONTROL) begin
        st_nxt.prdata[7:0] = e_ctrl;
      end else if (idx == IDX_ANALOG_PIN_CONFIG) begin
        st_nxt.prdata[2:0] = st_r.e_analog;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end else if (access) begin
      st_nxt.pslverr = 1'b0;
    end

    // CPU reading the input word frees the buffer; a word ending now keeps it full
    if (rd_now && idx == IDX_PORT_D_PINS && st_r.mode && !wr_end) begin
      st_nxt.input_word_waiting = 1'b0;
    end

    if (wr_now) begin
      if (idx == IDX_PORT_C_PINS) begin
        st_nxt.c_latch = pwdata[7:0];
      end else if (idx == IDX_PORT_D_PINS) begin
        st_nxt.d_latch = pwdata[7:0];
        if (st_r.mode) begin
          st_nxt.output_word_pending = 1'b1;
        end
      end else if (idx == IDX_PORT_E_PINS) begin
        st_nxt.e_latch = pwdata[2:0];
      end else if (idx == IDX_PORT_C_DIRECTION) begin
        st_nxt.c_dir = pwdata[7:0];
      end else if (idx == IDX_PORT_D_DIRECTION) begin
        st_nxt.d_dir = pwdata[7:0];
      end else if (idx == IDX_PORT_E_DIRECTION_SLAVE_CONTROL) begin
        st_nxt.e_dir = pwdata[2:0];
        st_nxt.mode = pwdata[BIT_SLAVE_PORT_MODE_SELECT];
        // Writing zero clears overrun; a new overrun this cycle wins
        if (!pwdata[BIT_INPUT_OVERRUN] && !(wr_end && st_r.input_word_waiting)) begin
          st_nxt.input_overrun = 1'b0;
        end
      end else if (idx == IDX_ANALOG_PIN_CONFIG) begin
        st_nxt.e_analog = pwdata[2:0];
      end
    end

    // Status flags are meaningless outside slave mode
    if (!st_r.mode) begin
      st_nxt.input_word_waiting = 1'b0;
      st_nxt.output_word_pending = 1'b0;
    end

    // ***********************************************
    // Pin drivers
    // ***********************************************
    // Timer, capture and serial units drive through the override path
    st_nxt.c_oe = c_oe_calc;
    st_nxt.c_out = c_out_calc;
    st_nxt.d_out = st_r.d_latch;
    if (st_r.mode) begin
      // External processor owns the bus direction; direction register ignored
      st_nxt.d_oe = {8{rd_act_now}};
    end else begin
      st_nxt.d_oe = ~st_r.d_dir;
    end
    st_nxt.e_out = st_r.e_latch;
    // Direction still rules in analog mode, so a wrong setting fights the source
    st_nxt.e_oe = ~st_r.e_dir;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign port_c_out = st_r.c_out;
  assign port_c_oe = st_r.c_oe;
  assign port_d_out = st_r.d_out;
  assign port_d_oe = st_r.d_oe;
  assign port_e_out = st_r.e_out;
  assign port_e_oe = st_r.e_oe;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_wr_end;
    st_r.wr_act && !wr_act_now;
  endsequence

  sequence seq_rd_start;
    rd_act_now && !st_r.rd_act;
  endsequence

  sequence seq_read_e_ctrl;
    setup && !pwrite && idx == IDX_PORT_E_DIRECTION_SLAVE_CONTROL ##1 access;
  endsequence

  a_c_dir_hiz: assert property (
    (st_r.c_dir == 8'hFF && periph_sel == 8'h00) |=> port_c_oe == 8'h00)
    else $error("port C pin driven while set as input");

  a_c_dir_drive: assert property (
    (st_r.c_dir == 8'h00 && periph_sel == 8'h00)
    |=> (port_c_oe == 8'hFF && port_c_out == $past(st_r.c_latch)))
    else $error("port C output does not drive latch value");

  a_c_periph_data: assert property (
    periph_sel == 8'hFF |=> port_c_out == $past(periph_out))
    else $error("peripheral data not routed to port C");

  a_c_periph_oe: assert property (
    (periph_sel == 8'h00 && periph_oe == 8'hFF && st_r.c_dir == 8'hFF)
    |=> port_c_oe == 8'h00)
    else $error("unselected peripheral enable reached port C");

  a_e_analog_zero: assert property (
    (setup && idx == IDX_PORT_E_PINS && st_r.e_analog == 3'h7) |=> st_r.prdata[2:0] == 3'h0)
    else $error("analog port E pin read non-zero");

  a_e_reserved_zero: assert property (
    seq_read_e_ctrl |-> (prdata[BIT_E_RESERVED] == 1'b0 && prdata[31:8] == 24'h0))
    else $error("reserved control bits read non-zero");

  a_ibf_on_write: assert property (
    (seq_wr_end and st_r.mode) |=> st_r.input_word_waiting)
    else $error("input word not flagged after external write");

  a_input_overrun_on_overrun: assert property (
    (seq_wr_end and st_r.input_word_waiting) |=> st_r.input_overrun)
    else $error("overrun not flagged");

  a_input_overrun_sticky: assert property (
    (st_r.input_overrun && !wr_now) |=> st_r.input_overrun)
    else $error("overrun cleared without software write");

  a_obf_cleared: assert property (
    (seq_rd_start and !(wr_now && idx == IDX_PORT_D_PINS)) |=> !st_r.output_word_pending)
    else $error("output-full still set after external read");

  a_mode_off_clear: assert property (
    !st_r.mode |=> (!st_r.input_word_waiting && !st_r.output_word_pending))
    else $error("status flags set outside slave mode");

  a_psp_drive: assert property (
    (st_r.mode && rd_act_now) |=> (port_d_oe == 8'hFF && port_d_out == $past(st_r.d_latch)))
    else $error("slave port read not driving port D");

  a_d_dir_io: assert property (
    !st_r.mode |=> port_d_oe == ~$past(st_r.d_dir))
    else $error("port D driver disagrees with direction");

  a_e_dir_drive: assert property (
    1'b1 |=> port_e_oe == ~$past(st_r.e_dir))
    else $error("port E driver disagrees with direction");

  a_apb_ready: assert property (
    setup |=> (pready ##1 !pready))
    else $error("access phase not one cycle");

  sequence seq_cpu_read_d;
    rd_now && idx == IDX_PORT_D_PINS && st_r.mode;
  endsequence

  sequence seq_e_ctrl_write;
    wr_now && idx == IDX_PORT_E_DIRECTION_SLAVE_CONTROL;
  endsequence

  a_ibf_cpu_clear: assert property (
    (seq_cpu_read_d and !wr_end) |=> !st_r.input_word_waiting)
    else $error("input-full kept after CPU read");

  a_ibf_hold: assert property (
    (st_r.input_word_waiting && st_r.mode && !rd_now) |=> st_r.input_word_waiting)
    else $error("input-full dropped without CPU read");

  a_obf_cpu_set: assert property (
    (wr_now && idx == IDX_PORT_D_PINS && st_r.mode) |=> st_r.output_word_pending)
    else $error("output-full not set by CPU write");

  a_obf_hold: assert property (
    (st_r.output_word_pending && st_r.mode && !rd_start) |=> st_r.output_word_pending)
    else $error("output-full dropped without external read");

  a_input_overrun_sw_clear: assert property (
    (seq_e_ctrl_write and !pwdata[BIT_INPUT_OVERRUN] && !wr_end) |=> !st_r.input_overrun)
    else $error("overrun not cleared by software");

  a_input_overrun_write_one: assert property (
    (seq_e_ctrl_write and pwdata[BIT_INPUT_OVERRUN] && st_r.input_overrun) |=> st_r.input_overrun)
    else $error("overrun cleared by writing one");

  a_mode_write: assert property (
    seq_e_ctrl_write |=> st_r.mode == $past(pwdata[BIT_SLAVE_PORT_MODE_SELECT]))
    else $error("mode bit not taken from write");

  a_psp_latch: assert property (
    wr_act_now |=> st_r.d_in_latch == $past(st_r.d_sync2))
    else $error("slave port byte not latched");

  a_psp_float: assert property (
    (st_r.mode && !rd_act_now) |=> port_d_oe == 8'h00)
    else $error("port D driven outside external read");

  a_psp_read_latch: assert property (
    (setup && idx == IDX_PORT_D_PINS && st_r.mode) |=> prdata[7:0] == $past(st_r.d_in_latch))
    else $error("CPU read of slave port byte wrong");

  a_c_pin_read: assert property (
    (setup && idx == IDX_PORT_C_PINS) |=> prdata[7:0] == $past(st_r.c_sync2))
    else $error("port C read not pin levels");

  a_d_pin_read: assert property (
    (setup && idx == IDX_PORT_D_PINS && !st_r.mode) |=> prdata[7:0] == $past(st_r.d_sync2))
    else $error("port D read not pin levels");

  a_e_pin_read: assert property (
    (setup && idx == IDX_PORT_E_PINS && st_r.e_analog == 3'h0)
    |=> prdata[2:0] == $past(st_r.e_sync2))
    else $error("digital port E read not pin levels");

  a_c_latch_write: assert property (
    (wr_now && idx == IDX_PORT_C_PINS) |=> st_r.c_latch == $past(pwdata[7:0]))
    else $error("port C latch not written");

  a_c_dir_write: assert property (
    (wr_now && idx == IDX_PORT_C_DIRECTION) |=> st_r.c_dir == $past(pwdata[7:0]))
    else $error("port C direction not written");

  a_d_dir_write: assert property (
    (wr_now && idx == IDX_PORT_D_DIRECTION) |=> st_r.d_dir == $past(pwdata[7:0]))
    else $error("port D direction not written");

  a_e_out_latch: assert property (
    1'b1 |=> port_e_out == $past(st_r.e_latch))
    else $error("port E drive value not from latch");

endmodule

// file: hw/gpc_pkg.sv
// Constants and state type for the port C/D/E block with slave-port control
package gpc_pkg;

  // ***********************************************
  // Bus geometry
  // ***********************************************
  localparam int GPC_ADDR_W = 12;
  localparam int GPC_IDX_W = 10;

  // ***********************************************
  // Register indexes; byte address is four times the index
  // ***********************************************
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_C_PINS = 10'h007;
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_D_PINS = 10'h008;
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_E_PINS = 10'h009;
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_C_DIRECTION = 10'h087;
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_D_DIRECTION = 10'h088;
  localparam logic [GPC_IDX_W-1:0] IDX_PORT_E_DIRECTION_SLAVE_CONTROL = 10'h089;
  localparam logic [GPC_IDX_W-1:0] IDX_ANALOG_PIN_CONFIG = 10'h09F;

  // ***********************************************
  // Field positions of the port E direction / slave control register
  // ***********************************************
  localparam int BIT_INPUT_WORD_WAITING = 7;
  localparam int BIT_OUTPUT_WORD_PENDING = 6;
  localparam int BIT_INPUT_OVERRUN = 5;
  localparam int BIT_SLAVE_PORT_MODE_SELECT = 4;
  localparam int BIT_E_RESERVED = 3;

  // Port E pin roles in slave-port mode
  localparam int PIN_READ_STROBE = 0;
  localparam int PIN_WRITE_STROBE = 1;
  localparam int PIN_CHIP_SELECT = 2;

  // Port C pins shared with on-chip peripherals
  localparam int PIN_TIMER_OSC_OUT = 0;
  localparam int PIN_TIMER_OSC_IN = 1;
  localparam int PIN_CAPTURE_COMPARE_PWM = 2;
  localparam int PIN_SERIAL_TX_CLOCK = 6;
  localparam int PIN_SERIAL_RX_DATA = 7;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hFF;
  localparam logic [2:0] RST_PORT_E_DIRECTION = 3'h7;
  localparam logic [2:0] RST_ANALOG_SELECT = 3'h7;
  localparam logic [7:0] RST_LATCH = 8'h00;

  typedef struct packed {
    logic [7:0] c_sync1;
    logic [7:0] c_sync2;
    logic [7:0] d_sync1;
    logic [7:0] d_sync2;
    logic [2:0] e_sync1;
    logic [2:0] e_sync2;
    logic [7:0] c_latch;
    logic [7:0] c_dir;
    logic [7:0] d_latch;
    logic [7:0] d_dir;
    logic [7:0] d_in_latch;
    logic [2:0] e_latch;
    logic [2:0] e_dir;
    logic [2:0] e_analog;
    logic mode;
    logic input_word_waiting;
    logic output_word_pending;
    logic input_overrun;
    logic wr_act;
    logic rd_act;
    logic [7:0] c_out;
    logic [7:0] c_oe;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [2:0] e_out;
    logic [2:0] e_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gpc_state_t;

endpackage

// file: sim/gpc_pin_model.sv
// Outside world of the port block: pin levels and an 8-bit host on the slave port
module gpc_pin_model
  import gpc_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic [7:0] port_c_out, // Block drive, port C
  input wire logic [7:0] port_c_oe, // Block enable, port C
  input wire logic [7:0] port_d_out, // Block drive, port D
  input wire logic [7:0] port_d_oe, // Block enable, port D
  input wire logic [2:0] port_e_out, // Block drive, port E
  input wire logic [2:0] port_e_oe, // Block enable, port E
  output logic [7:0] port_c_in, // Resolved port C pins
  output logic [7:0] port_d_in, // Resolved port D pins
  output logic [2:0] port_e_in // Resolved port E pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c_ext = 8'h00;
  logic [7:0] d_ext = 8'h00;
  logic [2:0] e_ext = 3'h7;

  // Where the block drives it wins, elsewhere the outside level shows
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & c_ext);
  assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & d_ext);
  assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & e_ext);

  // Host write: chip select and write strobe low, data held for the whole strobe
  task automatic host_write(input logic [7:0] data, input int hold);
    @(posedge pclk);
    d_ext <= data;
    e_ext <= 3'h1;
    repeat (hold) @(posedge pclk);
    e_ext <= 3'h7;
    d_ext <= ~data; // Released bus must not keep showing the old byte
    repeat (8) @(posedge pclk);
  endtask

  // Host read: chip select and read strobe low, byte taken just before release
  task automatic host_read(output logic [7:0] data, input int hold);
    @(posedge pclk);
    e_ext <= 3'h2;
    repeat (hold) @(posedge pclk);
    data = port_d_in;
    e_ext <= 3'h7;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the port C/D/E block
module tb
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_C = {IDX_PORT_C_PINS, 2'b00};
  localparam logic [11:0] A_D = {IDX_PORT_D_PINS, 2'b00};
  localparam logic [11:0] A_E = {IDX_PORT_E_PINS, 2'b00};
  localparam logic [11:0] A_CD = {IDX_PORT_C_DIRECTION, 2'b00};
  localparam logic [11:0] A_DD = {IDX_PORT_D_DIRECTION, 2'b00};
  localparam logic [11:0] A_EC = {IDX_PORT_E_DIRECTION_SLAVE_CONTROL, 2'b00};
  localparam logic [11:0] A_AN = {IDX_ANALOG_PIN_CONFIG, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] periph_sel = 8'h00;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe = 8'h00;
  logic [7:0] port_c_in, port_c_out, port_c_oe, port_d_in, port_d_out, port_d_oe;
  logic [2:0] port_e_in, port_e_out, port_e_oe;
  int n_fail = 0;
  int checks = 0;

  gpc_ports u_gpc_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_c_in(port_c_in), .port_c_out(port_c_out),
    .port_c_oe(port_c_oe), .periph_sel(periph_sel), .periph_out(periph_out),
    .periph_oe(periph_oe), .port_d_in(port_d_in), .port_d_out(port_d_out),
    .port_d_oe(port_d_oe), .port_e_in(port_e_in), .port_e_out(port_e_out),
    .port_e_oe(port_e_oe));
  gpc_pin_model u_gpc_pin_model (.pclk(pclk), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
    .port_d_out(port_d_out), .port_d_oe(port_d_oe), .port_e_out(port_e_out),
    .port_e_oe(port_e_oe), .port_c_in(port_c_in), .port_d_in(port_d_in),
    .port_e_in(port_e_in));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer; an idle edge first keeps strobes from being assigned twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, 4'h0, r, e);
    check(r, {24'h0, exp}, what);
  endtask

  task automatic t_reset();
    rd(A_CD, 8'hFF, "c dir rst");
    rd(A_DD, 8'hFF, "d dir rst");
    rd(A_EC, 8'h07, "e ctrl rst");
    rd(A_AN, 8'h07, "analog rst");
    check(32'({port_c_oe, port_d_oe, port_e_oe}), 32'h0000_0000, "oe rst");
  endtask

  task automatic t_port_c();
    logic [31:0] r;
    logic e;
    u_gpc_pin_model.c_ext <= 8'h3C;
    wr(A_C, 8'hA5);
    apb(1'b1, A_CD, 8'h00, 4'h0, r, e);
    rd(A_CD, 8'hFF, "strobe off");
    wr(A_CD, 8'h0F); // Whole-byte write, never bit ops
    repeat (4) @(posedge pclk);
    check(32'(port_c_oe), 32'h0000_00F0, "c oe");
    check(32'(port_c_out & port_c_oe), 32'h0000_00A0, "c out");
    rd(A_C, 8'hAC, "c pins");
  endtask

  task automatic t_periph();
    @(posedge pclk);
    periph_sel <= 8'hC5;
    periph_out <= 8'h41;
    periph_oe <= 8'h8F;
    repeat (3) @(posedge pclk);
    check(32'(port_c_oe), 32'h0000_0085 | 32'h0000_0030, "ovr oe");
    check(32'(port_c_out & port_c_oe), 32'h0000_0021, "ovr out");
    periph_sel <= 8'h00;
    repeat (3) @(posedge pclk);
    check(32'(port_c_oe), 32'h0000_00F0, "no ovr");
  endtask

  task automatic t_port_d();
    wr(A_D, 8'h5A);
    wr(A_DD, 8'h00);
    repeat (4) @(posedge pclk);
    check(32'({port_d_oe, port_d_out}), 32'h0000_FF5A, "d drive");
    rd(A_D, 8'h5A, "d pins");
    wr(A_DD, 8'hFF);
  endtask

  task automatic t_port_e();
    wr(A_E, 8'h05);
    wr(A_EC, 8'h00);
    repeat (4) @(posedge pclk);
    check(32'({port_e_oe, port_e_out}), 32'h0000_003D, "e drive analog");
    rd(A_E, 8'h00, "analog reads 0");
    wr(A_AN, 8'h00);
    repeat (4) @(posedge pclk);
    rd(A_E, 8'h05, "digital e");
    wr(A_EC, 8'h07); // Back to inputs
  endtask

  task automatic t_slave();
    logic [7:0] b;
    wr(A_EC, 8'hD7); // Slave mode on; port E stays inputs and digital from t_port_e
    rd(A_EC, 8'h17, "status ro");
    u_gpc_pin_model.host_write(8'h3C, 4);
    rd(A_EC, 8'h97, "ibf set");
    u_gpc_pin_model.host_write(8'hC3, 8);
    rd(A_EC, 8'hB7, "overrun");
    rd(A_D, 8'hC3, "bus bits");
    rd(A_EC, 8'h37, "ibf clr");
    wr(A_EC, 8'h17);
    rd(A_EC, 8'h17, "ovr clr");
    wr(A_D, 8'h96);
    rd(A_EC, 8'h57, "obf set");
    u_gpc_pin_model.host_read(b, 6);
    check(32'(b), 32'h0000_0096, "host read");
    rd(A_EC, 8'h17, "obf clr");
    wr(A_EC, 8'h07);
    rd(A_EC, 8'h07, "mode off");
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 8'h00, 4'h0, r, e);
    check(r, 32'h0000_0000, "unmapped data");
    check(32'(e), 32'h0000_0001, "unmapped err");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port_c();
    t_periph();
    t_port_d();
    t_port_e();
    t_slave();
    t_unmapped();
    give_verdict();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    $display("MISMATCH t=%0t timeout", $time);
    give_verdict();
  end
endmodule
